// *** prc_pkg.sv ***
// Package: register map, field positions and reset values of the
// peripheral reset control block. Assumes a 32-bit APB register bus.
package prc_pkg;

  localparam logic [31:0] sysctl_base             = 32'h400fe000;
  localparam logic [11:0] off_reset_ctrl_analog_watchdog = 12'h040;
  localparam logic [11:0] off_reset_ctrl_timers_serial   = 12'h044;
  localparam logic [11:0] off_reset_ctrl_ports           = 12'h048;
  localparam logic [11:0] off_deep_sleep_port_clock_gate = 12'h128;
  localparam logic [11:0] off_capability_reg_one         = 12'h010;
  localparam logic [11:0] off_capability_reg_two         = 12'h014;
  localparam logic [11:0] off_capability_reg_four        = 12'h01c;
  localparam logic [11:0] off_sleep_state                = 12'h060;

  localparam int pos_analog_reset      = 16;
  localparam int pos_watchdog_reset    = 3;
  localparam int pos_gp_counter0_reset = 16;
  localparam int pos_gp_counter1_reset = 17;
  localparam int pos_gp_counter2_reset = 18;
  localparam int pos_two_wire_reset    = 12;
  localparam int pos_sync_serial_reset = 4;
  localparam int pos_async_serial1_reset = 1;
  localparam int pos_async_serial0_reset = 0;
  localparam int port_count            = 5;

  localparam logic [31:0] rw_mask_analog_watchdog = 32'h00010008;
  localparam logic [31:0] rw_mask_timers_serial   = 32'h00071013;
  localparam logic [31:0] rw_mask_ports           = 32'h0000001f;
  localparam logic [31:0] reset_value_zero        = 32'h00000000;

endpackage : prc_pkg

// *** prc_sync.sv ***
// Three-flop synchroniser for one level arriving from outside the clock domain.
// Assumes the source is a plain level; output changes once stages two and three agree.
`timescale 1ns/1ps
module prc_sync
(
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic level_i,
  output logic      level_o
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage1  <= 1'b0;
      stage2  <= 1'b0;
      stage3  <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      stage1 <= level_i;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level_o <= stage3;
    end
  end
endmodule : prc_sync

// *** prc_masked_reg.sv ***
// One 32-bit reset control register whose writes are masked by a capability word.
// Assumes write strobe already qualified by the APB access phase.
`timescale 1ns/1ps
module prc_masked_reg
#(
  parameter logic [31:0] rw_mask = 32'h00000000
)
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        write_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] capability_i,
  output logic      [31:0] value_o
);
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      value_o <= prc_pkg::reset_value_zero;
    else if (write_i)
      // Unimplemented units keep their bit; reserved bits stay zero
      value_o <= (value_o & ~(capability_i & rw_mask))
               | (wdata_i & capability_i & rw_mask);
  end
endmodule : prc_masked_reg

// *** peripheral_reset_control.sv ***
// Top of the peripheral reset control block: APB slave, software reset
// registers, deep-sleep port clock gates and per-unit reset outputs.
// Assumes capability words come from static configuration on the same clock
// and that the deep-sleep indication is an asynchronous level.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
//
// Contract
// RL1: Capability registers mask reset register writes
// RL2: Reset registers at base offsets 040/044/048
// RL3: Register zero: ADC bit16, watchdog bit3
// RL4: Timer resets at bits 16,17,18
// RL5: Two-wire 12, sync 4, async 1,0
// RL6: Port resets A..E in bits 0..4
// RL7: Deep-sleep gate bits A..E, reset zero
// RL8: Gates apply only in deep sleep
// RL9: Gated-off unit access gives bus fault
// RL10: Set bit holds peripheral in reset
module peripheral_reset_control
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [31:0] capability_reg_one_i,
  input  wire logic [31:0] capability_reg_two_i,
  input  wire logic [31:0] capability_reg_four_i,
  input  wire logic        deep_sleep_i,
  input  wire logic [4:0]  port_access_i,
  output logic             port_access_fault_o,
  output logic             analog_reset_o,
  output logic             watchdog_reset_bit_o,
  output logic [2:0]       gp_counter_reset_o,
  output logic             two_wire_unit_reset_bit_o,
  output logic             sync_serial_reset_bit_o,
  output logic [1:0]       async_serial_reset_o,
  output logic [4:0]       port_reset_o,
  output logic [4:0]       port_clock_enable_o
);

  typedef enum logic [1:0] {idle_st, access_st, done_st} apb_state_type;

  apb_state_type    apb_state;
  logic [31:0]      reset_ctrl_analog_watchdog;
  logic [31:0]      reset_ctrl_timers_serial;
  logic [31:0]      reset_ctrl_ports;
  logic [4:0]       deep_sleep_port_clock_gate;
  logic             deep_sleep;
  logic [11:0]      offset;
  logic             in_space;
  logic             wr_analog;
  logic             wr_timers;
  logic             wr_ports;
  logic [31:0]      next_rdata;
  logic             next_err;

  prc_sync sleep_sync
  (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .level_i (deep_sleep_i),
    .level_o (deep_sleep)
  );

  // Decode against the system control base
  assign offset   = paddr_i[11:0];
  assign in_space = (paddr_i[31:12] == prc_pkg::sysctl_base[31:12]); // RL2
  assign wr_analog = (apb_state == access_st) && pwrite_i && in_space
                   && (offset == prc_pkg::off_reset_ctrl_analog_watchdog); // RL2
  assign wr_timers = (apb_state == access_st) && pwrite_i && in_space
                   && (offset == prc_pkg::off_reset_ctrl_timers_serial); // RL2
  assign wr_ports  = (apb_state == access_st) && pwrite_i && in_space
                   && (offset == prc_pkg::off_reset_ctrl_ports); // RL2

  prc_masked_reg #(.rw_mask(prc_pkg::rw_mask_analog_watchdog)) reg_zero
  (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .write_i      (wr_analog),
    .wdata_i      (pwdata_i),
    .capability_i (capability_reg_one_i), // RL1
    .value_o      (reset_ctrl_analog_watchdog) // RL3
  );

  prc_masked_reg #(.rw_mask(prc_pkg::rw_mask_timers_serial)) reg_one
  (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .write_i      (wr_timers),
    .wdata_i      (pwdata_i),
    .capability_i (capability_reg_two_i), // RL1
    .value_o      (reset_ctrl_timers_serial) // RL4 RL5
  );

  prc_masked_reg #(.rw_mask(prc_pkg::rw_mask_ports)) reg_two
  (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .write_i      (wr_ports),
    .wdata_i      (pwdata_i),
    .capability_i (capability_reg_four_i), // RL1
    .value_o      (reset_ctrl_ports) // RL6
  );

  // Deep-sleep gate bits, plain read/write
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      deep_sleep_port_clock_gate <= 5'h00; // RL7
    else if ((apb_state == access_st) && pwrite_i && in_space
             && (offset == prc_pkg::off_deep_sleep_port_clock_gate))
      deep_sleep_port_clock_gate <= pwdata_i[prc_pkg::port_count-1:0]; // RL7
  end

  // Read mux; any unmapped address answers with an error
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (!in_space)
      next_err = 1'b1;
    else
    begin
      unique case (offset)
        prc_pkg::off_reset_ctrl_analog_watchdog: next_rdata = reset_ctrl_analog_watchdog;
        prc_pkg::off_reset_ctrl_timers_serial:   next_rdata = reset_ctrl_timers_serial;
        prc_pkg::off_reset_ctrl_ports:           next_rdata = reset_ctrl_ports;
        prc_pkg::off_deep_sleep_port_clock_gate:
          next_rdata = {27'h0, deep_sleep_port_clock_gate}; // RL7
        prc_pkg::off_capability_reg_one:  next_rdata = capability_reg_one_i;
        prc_pkg::off_capability_reg_two:  next_rdata = capability_reg_two_i;
        prc_pkg::off_capability_reg_four: next_rdata = capability_reg_four_i;
        prc_pkg::off_sleep_state:         next_rdata = {31'h0, deep_sleep}; // RL8
        default:                          next_err   = 1'b1;
      endcase
    end
  end

  // APB slave: one wait state, answer in the second access cycle
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      apb_state <= idle_st;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      unique case (apb_state)
        idle_st:
          if (psel_i && !penable_i)
            apb_state <= access_st;
        access_st:
        begin
          apb_state <= done_st;
          pready_o  <= 1'b1;
          pslverr_o <= next_err;
          prdata_o  <= pwrite_i ? 32'h00000000 : next_rdata;
        end
        done_st:
          apb_state <= (psel_i && !penable_i) ? access_st : idle_st;
      endcase
    end
  end

  // Peripheral resets follow their control bits one clock later
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      analog_reset_o            <= 1'b0;
      watchdog_reset_bit_o      <= 1'b0;
      gp_counter_reset_o        <= 3'h0;
      two_wire_unit_reset_bit_o <= 1'b0;
      sync_serial_reset_bit_o   <= 1'b0;
      async_serial_reset_o      <= 2'h0;
      port_reset_o              <= 5'h00;
    end
    else
    begin
      analog_reset_o       <= reset_ctrl_analog_watchdog[prc_pkg::pos_analog_reset]; // RL10
      watchdog_reset_bit_o <= reset_ctrl_analog_watchdog[prc_pkg::pos_watchdog_reset]; // RL10
      gp_counter_reset_o   <= reset_ctrl_timers_serial[prc_pkg::pos_gp_counter2_reset:
                                                       prc_pkg::pos_gp_counter0_reset]; // RL10
      two_wire_unit_reset_bit_o <= reset_ctrl_timers_serial[prc_pkg::pos_two_wire_reset]; // RL10
      sync_serial_reset_bit_o   <= reset_ctrl_timers_serial[prc_pkg::pos_sync_serial_reset]; // RL10
      async_serial_reset_o <= reset_ctrl_timers_serial[prc_pkg::pos_async_serial1_reset:
                                                       prc_pkg::pos_async_serial0_reset]; // RL10
      port_reset_o         <= reset_ctrl_ports[prc_pkg::port_count-1:0]; // RL10
    end
  end

  // Port clocks: gate bits only matter in deep sleep; outside it ports run
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      port_clock_enable_o <= 5'h1f;
    else if (deep_sleep)
      port_clock_enable_o <= deep_sleep_port_clock_gate; // RL8
    else
      port_clock_enable_o <= 5'h1f; // RL8
  end

  // Access to a port whose clock is stopped is a bus fault
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      port_access_fault_o <= 1'b0;
    else
      port_access_fault_o <= |(port_access_i & ~port_clock_enable_o); // RL9
  end

  a_write_masked : assert property (@(posedge clock_i) disable iff (reset_i) // RL1
    wr_ports |=> ((reset_ctrl_ports & ~capability_reg_four_i)
                  == ($past(reset_ctrl_ports) & ~capability_reg_four_i)))
    else $error("masked port reset bit changed");
  a_analog_masked : assert property (@(posedge clock_i) disable iff (reset_i) // RL1
    wr_analog |=> ((reset_ctrl_analog_watchdog & ~capability_reg_one_i)
                   == ($past(reset_ctrl_analog_watchdog) & ~capability_reg_one_i)))
    else $error("masked analog or watchdog bit changed");
  a_timers_masked : assert property (@(posedge clock_i) disable iff (reset_i) // RL1
    wr_timers |=> ((reset_ctrl_timers_serial & ~capability_reg_two_i)
                   == ($past(reset_ctrl_timers_serial) & ~capability_reg_two_i)))
    else $error("masked timer or serial bit changed");
  a_reserved_zero : assert property (@(posedge clock_i) disable iff (reset_i) // RL3
    ((reset_ctrl_analog_watchdog & ~prc_pkg::rw_mask_analog_watchdog) == 32'h0)
    && ((reset_ctrl_timers_serial & ~prc_pkg::rw_mask_timers_serial) == 32'h0))
    else $error("reserved reset bit set");
  a_analog_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL3
    wr_analog && capability_reg_one_i[16]
    |=> reset_ctrl_analog_watchdog[16] == $past(pwdata_i[16]))
    else $error("analog bit did not take write");
  a_watchdog_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL3
    wr_analog && capability_reg_one_i[3]
    |=> reset_ctrl_analog_watchdog[3] == $past(pwdata_i[3]))
    else $error("watchdog bit did not take write");
  a_ports_reserved : assert property (@(posedge clock_i) disable iff (reset_i) // RL6
    reset_ctrl_ports[31:5] == 27'h0)
    else $error("port register upper bits set");
  a_port_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL6
    wr_ports && capability_reg_four_i[4]
    |=> reset_ctrl_ports[4] == $past(pwdata_i[4]))
    else $error("port e bit did not take write");
  a_timer_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL4
    wr_timers && capability_reg_two_i[18] |=> reset_ctrl_timers_serial[18] == $past(pwdata_i[18]))
    else $error("timer two bit did not take write");
  a_counter_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL4
    wr_timers && capability_reg_two_i[16]
    |=> reset_ctrl_timers_serial[16] == $past(pwdata_i[16]))
    else $error("timer zero bit did not take write");
  a_serial_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL5
    wr_timers && capability_reg_two_i[12] |=> reset_ctrl_timers_serial[12] == $past(pwdata_i[12]))
    else $error("two-wire bit did not take write");
  a_async_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL5
    wr_timers && capability_reg_two_i[0]
    |=> reset_ctrl_timers_serial[0] == $past(pwdata_i[0]))
    else $error("async serial zero bit did not take write");
  a_decode_zero : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    wr_analog |-> paddr_i[11:0] == 12'h040)
    else $error("register zero decoded at wrong offset");
  a_ready_timing : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    (apb_state == access_st) |=> pready_o)
    else $error("access cycle not answered");
  a_ready_pulse : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_idle_quiet : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    (apb_state == idle_st) |=> !pready_o && !pslverr_o)
    else $error("answer given without access");
  a_err_qualified : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    pslverr_o |-> pready_o)
    else $error("error shown without ready");
  a_foreign_refused : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    (apb_state == access_st) && !in_space |=> pslverr_o)
    else $error("foreign base not refused");
  a_readonly_accepted : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    (apb_state == access_st) && in_space
    && (offset == prc_pkg::off_capability_reg_one) |=> !pslverr_o)
    else $error("read-only mirror access refused");
  a_write_rdata_zero : assert property (@(posedge clock_i) disable iff (reset_i) // RL2
    (apb_state == access_st) && pwrite_i |=> (prdata_o == 32'h00000000))
    else $error("read data not zero on write");
  a_gate_write : assert property (@(posedge clock_i) disable iff (reset_i) // RL7
    (apb_state == access_st) && pwrite_i && in_space
    && (offset == prc_pkg::off_deep_sleep_port_clock_gate)
    |=> deep_sleep_port_clock_gate == $past(pwdata_i[4:0]))
    else $error("gate bits did not take write");
  a_gate_awake : assert property (@(posedge clock_i) disable iff (reset_i) // RL8
    !deep_sleep ##1 !deep_sleep |-> port_clock_enable_o == 5'h1f)
    else $error("port clock gated outside deep sleep");
  a_gate_sleep : assert property (@(posedge clock_i) disable iff (reset_i) // RL7
    deep_sleep |=> port_clock_enable_o == $past(deep_sleep_port_clock_gate))
    else $error("deep sleep gate not applied");
  a_fault_gated : assert property (@(posedge clock_i) disable iff (reset_i) // RL9
    |(port_access_i & ~port_clock_enable_o) |=> port_access_fault_o)
    else $error("gated port access not faulted");
  a_fault_clear : assert property (@(posedge clock_i) disable iff (reset_i) // RL9
    !(|(port_access_i & ~port_clock_enable_o)) |=> !port_access_fault_o)
    else $error("fault raised without gated access");
  a_reset_hold : assert property (@(posedge clock_i) disable iff (reset_i) // RL10
    reset_ctrl_ports[0] ##1 reset_ctrl_ports[0] |-> port_reset_o[0])
    else $error("port reset not held");
  a_release_port : assert property (@(posedge clock_i) disable iff (reset_i) // RL10
    !reset_ctrl_ports[0] ##1 !reset_ctrl_ports[0] |-> !port_reset_o[0])
    else $error("port not released from reset");
  a_counter_follow : assert property (@(posedge clock_i) disable iff (reset_i) // RL10
    gp_counter_reset_o == $past(reset_ctrl_timers_serial[18:16]))
    else $error("timer resets do not follow control bits");

endmodule : peripheral_reset_control

// *** tb.sv ***
// Self-checking bench for the peripheral reset control block.
// Assumes an APB slave with one wait state and a three-flop-plus deep-sleep sync.
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] base = 32'h400fe000;
  logic        clock_i, reset_i, psel_i, penable_i, pwrite_i, deep_sleep_i;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, port_access_fault_o, er;
  logic [31:0] cap[3];
  logic [31:0] r[3];
  logic [31:0] mask[3] = '{32'h00010008, 32'h00071013, 32'h0000001f};
  logic [11:0] offs[3] = '{12'h040, 12'h044, 12'h048};
  logic [11:0] coff[3] = '{12'h010, 12'h014, 12'h01c};
  logic [4:0]  port_access_i, port_reset_o, port_clock_enable_o, gm;
  logic        analog_reset_o, watchdog_reset_bit_o, two_wire_unit_reset_bit_o;
  logic        sync_serial_reset_bit_o;
  logic [2:0]  gp_counter_reset_o;
  logic [1:0]  async_serial_reset_o;
  logic [31:0] d;
  int          err_count, checks;

  peripheral_reset_control DUT
  (
    .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .capability_reg_one_i(cap[0]),
    .capability_reg_two_i(cap[1]), .capability_reg_four_i(cap[2]),
    .deep_sleep_i(deep_sleep_i), .port_access_i(port_access_i),
    .port_access_fault_o(port_access_fault_o), .analog_reset_o(analog_reset_o),
    .watchdog_reset_bit_o(watchdog_reset_bit_o), .gp_counter_reset_o(gp_counter_reset_o),
    .two_wire_unit_reset_bit_o(two_wire_unit_reset_bit_o),
    .sync_serial_reset_bit_o(sync_serial_reset_bit_o),
    .async_serial_reset_o(async_serial_reset_o), .port_reset_o(port_reset_o),
    .port_clock_enable_o(port_clock_enable_o)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Request held until pready is sampled; one idle edge keeps drives apart
  task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      check("pready", 32'h0, 32'h1);
      tally_and_finish;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task do_reset;
    reset_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    r = '{32'h0, 32'h0, 32'h0};
    @(posedge clock_i);
  endtask : do_reset

  task check_outputs;
    check("resets", {analog_reset_o, watchdog_reset_bit_o, gp_counter_reset_o,
      two_wire_unit_reset_bit_o, sync_serial_reset_bit_o, async_serial_reset_o,
      port_reset_o}, {r[0][16], r[0][3], r[1][18:16], r[1][12], r[1][4], r[1][1:0],
      r[2][4:0]});
  endtask : check_outputs

  task tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #200000;
    err_count++;
    tally_and_finish;
  end

  initial
  begin
    void'($urandom(32'h9a19));
    {psel_i, penable_i, pwrite_i, deep_sleep_i} = 4'h0;
    {paddr_i, pwdata_i} = 64'h0;
    port_access_i = 5'h00;
    cap = '{32'hffffffff, 32'hffffffff, 32'hffffffff};
    reset_i = 1'b1;
    do_reset;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, base | 32'(offs[i]), 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, base | 32'h128, 32'h0);
    check("gate reset", rd, 32'h0);
    check("clock enables", 32'(port_clock_enable_o), 32'h1f);
    // Random capability words exercise masking on every register
    repeat (20)
    begin
      for (int i = 0; i < 3; i++)
        cap[i] <= (i == 0) ? $urandom : $urandom | mask[i] & $urandom;
      @(posedge clock_i);
      for (int i = 0; i < 3; i++)
      begin
        d = $urandom;
        apb(1'b1, base | 32'(offs[i]), d);
        r[i] = (r[i] & ~(cap[i] & mask[i])) | (d & cap[i] & mask[i]);
        check("write error", 32'(er), 32'h0);
        apb(1'b0, base | 32'(offs[i]), 32'h0);
        check("readback", rd, r[i]);
        check_outputs;
        apb(1'b0, base | 32'(coff[i]), 32'h0);
        check("capability", rd, cap[i]);
      end
    end
    // Unmapped offset and foreign base are refused and change nothing
    apb(1'b1, base | 32'h04c, 32'hffffffff);
    check("unmapped err", 32'(er), 32'h1);
    apb(1'b1, 32'h400fd040, 32'hffffffff);
    check("base err", 32'(er), 32'h1);
    apb(1'b0, base | 32'h040, 32'h0);
    check("untouched", rd, r[0]);
    // A write to a read-only mirror is accepted and has no effect
    apb(1'b1, base | 32'(coff[0]), 32'h0);
    check("read-only err", 32'(er), 32'h0);
    apb(1'b0, base | 32'(coff[0]), 32'h0);
    check("read-only kept", rd, cap[0]);
    deep_sleep_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    apb(1'b0, base | 32'h060, 32'h0);
    check("sleep state", rd, 32'h1);
    d = $urandom;
    gm = d[4:0];
    apb(1'b1, base | 32'h128, d);
    apb(1'b0, base | 32'h128, 32'h0);
    check("gate readback", rd, 32'(gm));
    check("sleep enables", 32'(port_clock_enable_o), 32'(gm));
    for (int p = 0; p < 5; p++)
    begin
      port_access_i <= 5'(1 << p);
      @(posedge clock_i);
      port_access_i <= 5'h00;
      @(posedge clock_i);
      // Fault pulse stands for the cycle after the sampled access
      check("fault", 32'(port_access_fault_o), 32'(!gm[p]));
    end
    deep_sleep_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    check("awake enables", 32'(port_clock_enable_o), 32'h1f);
    apb(1'b0, base | 32'h060, 32'h0);
    check("awake state", rd, 32'h0);
    // Reset in mid-run clears all three control registers
    do_reset;
    check_outputs;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, base | 32'(offs[i]), 32'h0);
      check("second reset", rd, 32'h0);
    end
    tally_and_finish;
  end
endmodule : tb
